// ===== bench/adc_capture_checker.sv
// Purpose: Port checks for the capture sequencer
// Assumes: Converter pins synchronous to SYS_CLK
// Notes:   Bound to adc_capture from the bench top
`timescale 1ns/100ps
module adc_capture_checker
    import capture_pkg::*;
(
    input wire logic        SYS_CLK,
    input wire logic        RST_N,
    input wire logic        START,
    input wire logic        TRIG_SEL,
    input wire logic        ADC_BUSY,
    input wire logic        ADC_CS_N,
    input wire logic        ADC_RD_N,
    input wire logic        ADC_CONVST_N,
    input wire logic        ADC_RESET_N,
    input sample_write_type SAMPLE_WR,
    input wire logic        BLOCK_DONE,
    input wire logic        CAPTURE_ACTIVE
);
    logic [5:0]  idle;
    logic [5:0]  since;
    logic        busy_q;
    logic [10:0] last_idx;

    default clocking cb @(posedge SYS_CLK);
    endclocking
    default disable iff (!RST_N);

    // Idle run of the bus, age of the read trigger edge, last stored index
    always_ff @(posedge SYS_CLK)
    begin
        if (!RST_N)
        begin
            idle     <= 6'h00;
            since    <= 6'h00;
            busy_q   <= 1'b0;
            last_idx <= 11'h000;
        end
        else
        begin
            idle   <= ADC_CS_N ? idle + {5'h00, idle != 6'h3F} : 6'h00;
            busy_q <= ADC_BUSY;
            if ((CAPTURE_ACTIVE && TRIG_SEL) ? (ADC_BUSY && !busy_q) : (!ADC_BUSY && busy_q))
                since <= 6'h00;
            else if (since != 6'h3F)
                since <= since + 6'h01;
            if (SAMPLE_WR.valid)
                last_idx <= SAMPLE_WR.index;
        end
    end

    a_strobe_width: assert property ($fell(ADC_CS_N) |-> !ADC_CS_N [*5] ##1 ADC_CS_N)
        else $error("strobe low time wrong");
    a_select_follows: assert property (ADC_CS_N == (ADC_RD_N && ADC_CONVST_N && ADC_RESET_N))
        else $error("chip select not with strobe");
    a_one_strobe: assert property ($onehot0({!ADC_RD_N, !ADC_CONVST_N, !ADC_RESET_N}))
        else $error("two strobes at once");
    a_quiet_before: assert property ($fell(ADC_CONVST_N) |-> idle >= 6'h19)
        else $error("activity too close before convert");
    a_quiet_after: assert property ($fell(ADC_CONVST_N) |-> ##5 ADC_CS_N [*8])
        else $error("activity too close after convert");
    a_read_latency: assert property ($fell(ADC_RD_N) |-> since >= 6'h21)
        else $error("read too soon after trigger edge");
    a_read_follows: assert property ((TRIG_SEL ? $rose(ADC_BUSY) : $fell(ADC_BUSY))
        && CAPTURE_ACTIVE |-> ##[33:48] ($fell(ADC_RD_N) || !CAPTURE_ACTIVE))
        else $error("no read after trigger edge");
    a_wr_after_read: assert property (SAMPLE_WR.valid |->
        ADC_RD_N && (!$past(ADC_RD_N, 2) || !$past(ADC_RD_N, 3)))
        else $error("sample stored without a read");
    a_wr_pulse: assert property (SAMPLE_WR.valid |=> !SAMPLE_WR.valid)
        else $error("store pulse too long");
    a_index_step: assert property (SAMPLE_WR.valid && SAMPLE_WR.index != 11'h000
        |-> SAMPLE_WR.index == last_idx + 11'h001)
        else $error("sample index out of order");
    a_done_rise: assert property ($rose(BLOCK_DONE) |->
        SAMPLE_WR.valid && SAMPLE_WR.index == 11'h7FF)
        else $error("done not with last sample");
    a_done_quiet: assert property ($past(BLOCK_DONE) |-> !SAMPLE_WR.valid)
        else $error("sample stored after block");
    a_done_hold: assert property ($fell(BLOCK_DONE) |-> $past(START) || $past(START, 2))
        else $error("done cleared without restart");
endmodule // adc_capture_checker

// ===== bench/adc_capture_tb.sv
// Purpose: Self-checking bench for the capture sequencer
// Assumes: Converter model on the far side; clock enable held high
// Notes:   A full block is too long to run; block end is left to the checker
`timescale 1ns/100ps
bind adc_capture adc_capture_checker u_adc_capture_checker (
    .SYS_CLK(SYS_CLK), .RST_N(RST_N), .START(START), .TRIG_SEL(TRIG_SEL), .ADC_BUSY(ADC_BUSY),
    .ADC_CS_N(ADC_CS_N), .ADC_RD_N(ADC_RD_N), .ADC_CONVST_N(ADC_CONVST_N), .ADC_RESET_N(ADC_RESET_N),
    .SAMPLE_WR(SAMPLE_WR), .BLOCK_DONE(BLOCK_DONE), .CAPTURE_ACTIVE(CAPTURE_ACTIVE));

module adc_capture_tb
    import capture_pkg::*;
;
    logic             SYS_CLK;
    logic             RST_N;
    logic             START;
    logic             HALT;
    logic             TRIG_SEL;
    logic             ADC_BUSY;
    logic [15:0]      ADC_DATA;
    logic             ADC_CS_N;
    logic             ADC_RD_N;
    logic             ADC_CONVST_N;
    logic             ADC_RESET_N;
    sample_write_type SAMPLE_WR;
    logic [15:0]      SCRATCH_WORD;
    logic             BLOCK_DONE;
    logic             CAPTURE_ACTIVE;
    int               fail_count;
    int               samples_checked;

    adc_capture u_adc_capture (.SYS_CLK(SYS_CLK), .RST_N(RST_N), .CE(1'b1), .START(START), .HALT(HALT),
        .TRIG_SEL(TRIG_SEL), .ADC_BUSY(ADC_BUSY), .ADC_DATA(ADC_DATA), .ADC_CS_N(ADC_CS_N),
        .ADC_RD_N(ADC_RD_N), .ADC_CONVST_N(ADC_CONVST_N), .ADC_RESET_N(ADC_RESET_N), .SAMPLE_WR(SAMPLE_WR),
        .SCRATCH_WORD(SCRATCH_WORD), .BLOCK_DONE(BLOCK_DONE), .CAPTURE_ACTIVE(CAPTURE_ACTIVE));

    converter_model u_converter_model (.clk(SYS_CLK), .cs_n(ADC_CS_N), .rd_n(ADC_RD_N),
        .convst_n(ADC_CONVST_N), .reset_n(ADC_RESET_N), .busy(ADC_BUSY), .data(ADC_DATA));

    // 250 MHz clock
    initial
    begin
        SYS_CLK = 1'b0;
        forever #2 SYS_CLK = ~SYS_CLK;
    end

    // Verdict and end of run
    task automatic end_of_test;
        $display("Checks %0d, mismatches %0d", samples_checked, fail_count);
        if (fail_count == 0 && samples_checked > 0)
            $display("DONE - PASS");
        else
            $display("DONE - FAIL");
        $finish;
    endtask

    // Bounded wait ran out
    task automatic timed_out;
        fail_count++;
        $display("Error at %0t: wait ran out", $time);
        end_of_test();
    endtask

    // Compare one word, unknowns never match
    task automatic check_word(input logic [15:0] got, input logic [15:0] exp);
        samples_checked++;
        if (got !== exp)
        begin
            fail_count++;
            $display("Error at %0t: got %h expected %h", $time, got, exp);
        end
    endtask

    // Restart: reset pulse then three discarded conversions
    task automatic start_init(input logic sel);
        int         i;
        int         n_rst;
        int         n_conv;
        int         n_rd;
        logic [2:0] p;
        n_rst  = 0;
        n_conv = 0;
        n_rd   = 0;
        p      = 3'h7;
        @(posedge SYS_CLK);
        TRIG_SEL <= sel;
        START    <= 1'b1;
        @(posedge SYS_CLK);
        START    <= 1'b0;
        for (i = 0; CAPTURE_ACTIVE !== 1'b1; i++)
        begin
            if (i > 3000)
                timed_out();
            @(negedge SYS_CLK);
            if (p[2] && !ADC_RESET_N)
                check_word(16'(n_conv), 16'h0000);
            n_rst  += int'(p[2] && !ADC_RESET_N);
            n_conv += int'(p[1] && !ADC_CONVST_N);
            n_rd   += int'(p[0] && !ADC_RD_N);
            check_word({15'h0000, SAMPLE_WR.valid}, 16'h0000);
            p = {ADC_RESET_N, ADC_CONVST_N, ADC_RD_N};
        end
        check_word(16'(n_rst), 16'h0001);
        check_word(16'(n_conv), 16'h0003);
        check_word(16'(n_rd), 16'h0003);
        check_word(SCRATCH_WORD, 16'hC003);
        check_word({15'h0000, BLOCK_DONE}, 16'h0000);
    endtask

    // Timed capture: conversion spacing, scratch word, stored samples
    task automatic capture(input logic sel, input int nsamp);
        int          k;
        int          j;
        int          cyc;
        int          last;
        int          chk;
        logic [15:0] base;
        logic [2:0]  p;
        k    = 0;
        j    = 0;
        last = 0;
        chk  = 0;
        base = sel ? 16'hC003 : 16'hC004;
        p    = {ADC_RESET_N, ADC_CONVST_N, ADC_RD_N};
        for (cyc = 1; k < nsamp; cyc++)
        begin
            if (cyc > nsamp * 216 + 600)
                timed_out();
            @(negedge SYS_CLK);
            if (chk > 0)
                chk--;
            if (p[1] && !ADC_CONVST_N)
            begin
                if (last > 0)
                    check_word(16'(cyc - last), 16'h00D8);
                last = cyc;
                j++;
            end
            if (!p[1] && ADC_CONVST_N)
                chk = 2;
            if (chk == 1)
                check_word(SCRATCH_WORD, ~(16'hC002 + 16'(j)));
            if (SAMPLE_WR.valid === 1'b1)
            begin
                check_word({5'h00, SAMPLE_WR.index}, 16'(k));
                check_word(SAMPLE_WR.data, base + 16'(k));
                k++;
            end
            p = {ADC_RESET_N, ADC_CONVST_N, ADC_RD_N};
        end
    endtask

    // Halt: no strobe, no store, capture flag low
    task automatic halt_check;
        int         i;
        logic [2:0] p;
        @(posedge SYS_CLK);
        HALT <= 1'b1;
        @(posedge SYS_CLK);
        HALT <= 1'b0;
        repeat (12) @(negedge SYS_CLK);
        p = {ADC_RESET_N, ADC_CONVST_N, ADC_RD_N};
        for (i = 0; i < 600; i++)
        begin
            @(negedge SYS_CLK);
            check_word({13'h0000, p & ~{ADC_RESET_N, ADC_CONVST_N, ADC_RD_N}}, 16'h0000);
            check_word({13'h0000, SAMPLE_WR.valid, CAPTURE_ACTIVE, BLOCK_DONE}, 16'h0000);
            p = {ADC_RESET_N, ADC_CONVST_N, ADC_RD_N};
        end
    endtask

    // Main sequence
    initial
    begin
        fail_count      = 0;
        samples_checked = 0;
        RST_N           = 1'b0;
        START           = 1'b0;
        HALT            = 1'b0;
        TRIG_SEL        = 1'b0;
        repeat (3) @(posedge SYS_CLK);
        RST_N <= 1'b1;
        @(negedge SYS_CLK);
        check_word({9'h000, ADC_CS_N, ADC_RD_N, ADC_CONVST_N, ADC_RESET_N, SAMPLE_WR.valid, BLOCK_DONE,
            CAPTURE_ACTIVE}, 16'h0078);
        check_word(SCRATCH_WORD, 16'h0000);
        start_init(1'b0);
        capture(1'b0, 16);
        halt_check();
        start_init(1'b1);
        capture(1'b1, 12);
        halt_check();
        end_of_test();
    end
endmodule // adc_capture_tb

// ===== bench/converter_model.sv
// Purpose: Behavioural 16-bit parallel converter on the far side
// Assumes: Pins synchronous to clk; conversion lasts about 100 cycles
// Notes:   Result word is 0xC in the top nibble, conversion number below
`timescale 1ns/100ps
module converter_model
(
    input  wire logic   clk,
    input  wire logic   cs_n,
    input  wire logic   rd_n,
    input  wire logic   convst_n,
    input  wire logic   reset_n,
    output logic        busy,
    output logic [15:0] data
);
    logic [7:0]  left;
    logic [11:0] num;
    logic [15:0] result;
    logic        conv_q;

    // Quiet converter at time zero
    initial
    begin
        left   = 8'h00;
        num    = 12'h000;
        result = 16'h0000;
        conv_q = 1'b1;
        busy   = 1'b0;
    end

    // Conversion run: count from convert-start, result lands at the end
    always @(posedge clk)
    begin
        conv_q <= convst_n;
        busy   <= (left > 8'h01) && (left < 8'h65);
        if (!reset_n)
        begin
            num  <= 12'h000;
            left <= 8'h00;
        end
        else if (conv_q && !convst_n)
        begin
            num  <= num + 12'h001;
            left <= 8'h66;
        end
        else if (left != 8'h00)
        begin
            left <= left - 8'h01;
            if (left == 8'h01)
                result <= {4'hC, num};
        end
    end

    // Word only while read; otherwise the inverse, never a stale copy
    assign data = (!cs_n && !rd_n) ? result : ~result;
endmodule // converter_model

// ===== rtl/adc_capture.sv
// Purpose: Timed block capture sequencer for a 16-bit parallel converter
// Assumes: Converter pins synchronous to SYS_CLK; one converter in the space
// Notes:   Samples leave on a write port to an external array
// Behaviour
// - One convert-start access per sample timer trigger.
// - Convert-start data goes to the scratch word, never the array.
// - A block is 2048 conversions and 2048 stored samples, a constant.
// - Sample reads follow the inverted busy edge, end of conversion.
// - After 2048 stored samples, further reads go to scratch.
// - Conversions and reads keep running until the processor halts them.
// - Sample timer clocked from the system clock divided by four.
// - Sample rate is timer clock over twice the period value.
// - Timer output toggles each period; one trigger per full cycle.
// - Period value is 27.
// - No converter access 100 ns before or 50 ns after convert-start.
// - About 130 ns from busy-derived edge to the read strobe.
// - Read, convert-start and reset strobes decoded from three addresses.
// - Completion flag raised to the processor after the full block.
// - Optionally trigger reads from non-inverted busy, during conversion.
// - Busy inverted before use as rising-edge read trigger.
// - Start-up: reset pulse, then three discarded conversions.
// - Chip select low during any access to the converter space.
`timescale 1ns/100ps
`include "capture_consts.svh"

module adc_capture
    import capture_pkg::*;
(
    input  wire logic         SYS_CLK,
    input  wire logic         RST_N,
    input  wire logic         CE,
    input  wire logic         START,
    input  wire logic         HALT,
    input  wire logic         TRIG_SEL,
    input  wire logic         ADC_BUSY,
    input  wire logic [15:0]  ADC_DATA,
    output logic              ADC_CS_N,
    output logic              ADC_RD_N,
    output logic              ADC_CONVST_N,
    output logic              ADC_RESET_N,
    output sample_write_type  SAMPLE_WR,
    output logic [15:0]       SCRATCH_WORD,
    output logic              BLOCK_DONE,
    output logic              CAPTURE_ACTIVE
);

    localparam logic [4:0] QUIET_BEFORE = 5'(`QUIET_BEFORE_CYC);
    localparam logic [3:0] QUIET_AFTER  = 4'(`QUIET_AFTER_CYC);
    localparam logic [5:0] READ_LAT     = 6'(`READ_LAT_CYC);

    seq_state_struct_type s;
    seq_state_struct_type next_s;
    access_rsp_type       rsp;
    logic                 timer_trig;
    logic                 trig_now;
    logic                 trig_rise;
    logic                 busy_fall;
    logic                 bus_busy;
    logic                 can_issue;

    // Sample timer runs only while capture is active
    sample_timer u_timer
    (
        .clk     (SYS_CLK),
        .rst_n   (RST_N),
        .ce      (CE),
        .enable  (s.active),
        .trigger (timer_trig)
    );

    // Decoded access engine toward the converter
    converter_access u_access
    (
        .clk      (SYS_CLK),
        .rst_n    (RST_N),
        .ce       (CE),
        .req      (s.req),
        .adc_data (ADC_DATA),
        .rsp      (rsp),
        .cs_n     (ADC_CS_N),
        .rd_n     (ADC_RD_N),
        .conv_n   (ADC_CONVST_N),
        .reset_n  (ADC_RESET_N)
    );

    // Read trigger polarity and edge detection
    assign trig_now  = TRIG_SEL ? ADC_BUSY : ~ADC_BUSY;
    assign trig_rise = trig_now & ~s.trig_prev;
    assign busy_fall = s.busy_prev & ~ADC_BUSY;
    assign bus_busy  = s.in_flight | s.req.valid;
    assign can_issue = ~bus_busy;

    // Sequencer next state
    always_comb
    begin
        next_s = s;
        next_s.req.valid = 1'b0;
        next_s.wr.valid = 1'b0;
        next_s.busy_prev = ADC_BUSY;
        next_s.trig_prev = trig_now;

        // Idle time since the last access, and guard after convert-start
        if (bus_busy)
            next_s.quiet = 5'h00;
        else if (s.quiet != QUIET_BEFORE)
            next_s.quiet = s.quiet + 5'h01;
        if (s.after_conv != 4'h0)
            next_s.after_conv = s.after_conv - 4'h1;
        if (s.read_pend && s.read_wait != 6'h00)
            next_s.read_wait = s.read_wait - 6'h01;

        // Completed access: route its word
        if (rsp.done)
        begin
            next_s.in_flight = 1'b0;
            if (s.kind == KIND_READ && s.st == ST_RUN && s.stored != `BLOCK_LENGTH)
            begin
                next_s.wr.valid = 1'b1;
                next_s.wr.index = s.stored[10:0];
                next_s.wr.data = rsp.data;
                next_s.stored = s.stored + 12'h001;
                if (s.stored == `BLOCK_LENGTH - 12'h001)
                    next_s.done = 1'b1;
            end
            else
            begin
                next_s.scratch = rsp.data;
            end
        end

        // Sequence through start-up and timed capture
        case (s.st)
            ST_IDLE:
            begin
            end
            ST_RESET:
            begin
                if (rsp.done && s.kind == KIND_RESET)
                begin
                    next_s.st = ST_INIT_CONV;
                    next_s.conv_pend = 1'b1;
                end
            end
            ST_INIT_CONV:
            begin
                if (rsp.done && s.kind == KIND_CONV)
                    next_s.st = ST_INIT_WAIT;
            end
            ST_INIT_WAIT:
            begin
                if (busy_fall)
                begin
                    next_s.st = ST_INIT_READ;
                    next_s.read_pend = 1'b1;
                    next_s.read_wait = READ_LAT;
                end
            end
            ST_INIT_READ:
            begin
                if (rsp.done && s.kind == KIND_READ)
                begin
                    if (s.init_left == 2'h1)
                    begin
                        next_s.st = ST_RUN;
                    end
                    else
                    begin
                        next_s.init_left = s.init_left - 2'h1;
                        next_s.conv_pend = 1'b1;
                        next_s.st = ST_INIT_CONV;
                    end
                end
            end
            ST_RUN:
            begin
                // Keep converting after the block until halted
                if (timer_trig)
                    next_s.conv_pend = 1'b1;
                if (trig_rise)
                begin
                    next_s.read_pend = 1'b1;
                    next_s.read_wait = READ_LAT;
                end
            end
            default:
            begin
                next_s.st = ST_IDLE;
            end
        endcase

        // Issue one access; reads first, convert-start only after quiet time
        if (can_issue)
        begin
            if (s.read_pend && s.read_wait == 6'h00 && s.after_conv == 4'h0)
            begin
                next_s.read_pend = 1'b0;
                next_s.req.valid = 1'b1;
                next_s.req.addr = `ADDR_READ;
                next_s.kind = KIND_READ;
                next_s.in_flight = 1'b1;
            end
            else if (s.conv_pend && s.quiet == QUIET_BEFORE && !(s.read_pend && s.read_wait == 6'h00))
            begin
                next_s.conv_pend = 1'b0;
                next_s.req.valid = 1'b1;
                next_s.req.addr = `ADDR_CONV;
                next_s.kind = KIND_CONV;
                next_s.in_flight = 1'b1;
                next_s.after_conv = QUIET_AFTER;
            end
        end

        // Restart begins a new block; halt stops timer and transfers
        if (START && !s.in_flight)
        begin
            next_s.st = ST_RESET;
            next_s.stored = 12'h000;
            next_s.done = 1'b0;
            next_s.conv_pend = 1'b0;
            next_s.read_pend = 1'b0;
            next_s.init_left = `INIT_DISCARDS;
            next_s.req.valid = 1'b1;
            next_s.req.addr = `ADDR_RESET;
            next_s.kind = KIND_RESET;
            next_s.in_flight = 1'b1;
        end
        else if (HALT)
        begin
            next_s.st = ST_IDLE;
            next_s.conv_pend = 1'b0;
            next_s.read_pend = 1'b0;
        end

        next_s.active = (next_s.st == ST_RUN);
    end

    // State register
    always_ff @(posedge SYS_CLK)
    begin
        if (!RST_N)
            s <= '0;
        else if (CE)
            s <= next_s;
    end

    // Registered outputs
    assign SAMPLE_WR      = s.wr;
    assign SCRATCH_WORD   = s.scratch;
    assign BLOCK_DONE     = s.done;
    assign CAPTURE_ACTIVE = s.active;

endmodule // adc_capture

// ===== rtl/capture_consts.svh
// Purpose: Constants for the timed converter block capture sequencer
// Assumes: SYS_CLK at 250 MHz; times given in ns, counts derived below
// Notes:   Least times round up to whole cycles
`ifndef CAPTURE_CONSTS_SVH
`define CAPTURE_CONSTS_SVH

// System clock rate
`define CLK_MHZ            32'h0000_00FA

// Strobe address map of the converter space
`define ADDR_READ          32'hA000_4000
`define ADDR_CONV          32'hA000_C000
`define ADDR_RESET         32'hA001_4000
`define REGION_MASK        32'hF000_0000
`define REGION_BASE        32'hA000_0000

// Capture block and start-up sequence
`define BLOCK_LENGTH       12'h800
`define INIT_DISCARDS      2'h3

// Sample timer: prescale of the input clock and period value
`define TIMER_PRESCALE     2'h3
`define TIMER_PERIOD       8'h1B

// Strobe low time per access (20 ns)
`define STROBE_NS          32'h0000_0014
`define STROBE_CYC         ((`STROBE_NS * `CLK_MHZ + 32'h0000_03E7) / 32'h0000_03E8)

// Quiet zone before the convert-start edge (100 ns)
`define QUIET_BEFORE_NS    32'h0000_0064
`define QUIET_BEFORE_CYC   ((`QUIET_BEFORE_NS * `CLK_MHZ + 32'h0000_03E7) / 32'h0000_03E8)

// Quiet zone after the convert-start edge (50 ns)
`define QUIET_AFTER_NS     32'h0000_0032
`define QUIET_AFTER_CYC    ((`QUIET_AFTER_NS * `CLK_MHZ + 32'h0000_03E7) / 32'h0000_03E8)

// Latency from the busy-derived edge to the read strobe (130 ns)
`define READ_LAT_NS        32'h0000_0082
`define READ_LAT_CYC       ((`READ_LAT_NS * `CLK_MHZ + 32'h0000_03E7) / 32'h0000_03E8)

`endif

// ===== rtl/capture_pkg.sv
// Purpose: Types shared by the capture sequencer files
// Assumes: Constants come from capture_consts.svh
// Notes:   Each module keeps all its state in one struct declared here
package capture_pkg;

    // Sequencer states
    typedef enum logic [2:0] {
        ST_IDLE      = 3'b000,
        ST_RESET     = 3'b001,
        ST_INIT_CONV = 3'b010,
        ST_INIT_WAIT = 3'b011,
        ST_INIT_READ = 3'b100,
        ST_RUN       = 3'b101
    } seq_state_type;

    // Kind of access in flight
    typedef enum logic [1:0] {
        KIND_CONV  = 2'b00,
        KIND_READ  = 2'b01,
        KIND_RESET = 2'b10
    } acc_kind_type;

    typedef struct packed {
        logic        valid;
        logic [31:0] addr;
    } access_req_type;

    typedef struct packed {
        logic        done;
        logic [15:0] data;
    } access_rsp_type;

    typedef struct packed {
        logic        valid;
        logic [10:0] index;
        logic [15:0] data;
    } sample_write_type;

    typedef struct packed {
        logic           active;
        logic           cs_n;
        logic           rd_n;
        logic           conv_n;
        logic           reset_n;
        logic [2:0]     cnt;
        access_rsp_type rsp;
    } access_state_type;

    typedef struct packed {
        logic [1:0] pre;
        logic [7:0] cnt;
        logic       out;
        logic       trig;
    } timer_state_type;

    typedef struct packed {
        seq_state_type    st;
        logic [1:0]       init_left;
        logic             conv_pend;
        logic             read_pend;
        logic [5:0]       read_wait;
        logic [3:0]       after_conv;
        logic [4:0]       quiet;
        logic [11:0]      stored;
        logic             busy_prev;
        logic             trig_prev;
        acc_kind_type     kind;
        logic             in_flight;
        access_req_type   req;
        sample_write_type wr;
        logic [15:0]      scratch;
        logic             done;
        logic             active;
    } seq_state_struct_type;

endpackage

// ===== rtl/converter_access.sv
// Purpose: One decoded read, convert-start or reset access toward the converter
// Assumes: A request arrives only while no access is active
// Notes:   Addresses outside the converter space complete with zero data and no strobe
`timescale 1ns/100ps
`include "capture_consts.svh"

module converter_access
    import capture_pkg::*;
(
    input  wire logic           clk,
    input  wire logic           rst_n,
    input  wire logic           ce,
    input  access_req_type      req,
    input  wire logic [15:0]    adc_data,
    output access_rsp_type      rsp,
    output logic                cs_n,
    output logic                rd_n,
    output logic                conv_n,
    output logic                reset_n
);

    localparam access_state_type ACCESS_IDLE = '{active: 1'b0, cs_n: 1'b1, rd_n: 1'b1, conv_n: 1'b1,
                                                 reset_n: 1'b1, cnt: 3'h0, rsp: '0};

    access_state_type s;
    access_state_type next_s;

    // Address decode, strobe timing and data capture
    always_comb
    begin
        next_s = s;
        next_s.rsp.done = 1'b0;
        if (!s.active)
        begin
            if (req.valid)
            begin
                next_s.active = 1'b1;
                next_s.cnt = 3'(`STROBE_CYC - 1);
                next_s.cs_n = !((req.addr & `REGION_MASK) == `REGION_BASE);
                if (req.addr == `ADDR_READ)
                    next_s.rd_n = 1'b0;
                else if (req.addr == `ADDR_CONV)
                    next_s.conv_n = 1'b0;
                else if (req.addr == `ADDR_RESET)
                    next_s.reset_n = 1'b0;
            end
        end
        else if (s.cnt != 3'h0)
        begin
            next_s.cnt = s.cnt - 3'h1;
        end
        else
        begin
            next_s = ACCESS_IDLE;
            next_s.rsp.done = 1'b1;
            next_s.rsp.data = s.cs_n ? 16'h0000 : adc_data;
        end
    end

    // State register
    always_ff @(posedge clk)
    begin
        if (!rst_n)
            s <= ACCESS_IDLE;
        else if (ce)
            s <= next_s;
    end

    assign rsp = s.rsp;
    assign cs_n = s.cs_n;
    assign rd_n = s.rd_n;
    assign conv_n = s.conv_n;
    assign reset_n = s.reset_n;

endmodule // converter_access

// ===== rtl/sample_timer.sv
// Purpose: Sample timer, prescaled input clock, clock-mode output
// Assumes: Enable low holds the timer cleared
// Notes:   One trigger pulse per full output cycle
`timescale 1ns/100ps
`include "capture_consts.svh"

module sample_timer
    import capture_pkg::*;
(
    input  wire logic clk,
    input  wire logic rst_n,
    input  wire logic ce,
    input  wire logic enable,
    output logic      trigger
);

    timer_state_type s;
    timer_state_type next_s;

    // Divide by four, count period ticks, toggle, trigger on rising output
    always_comb
    begin
        next_s = s;
        next_s.trig = 1'b0;
        if (!enable)
        begin
            next_s = '0;
        end
        else if (s.pre == `TIMER_PRESCALE)
        begin
            next_s.pre = 2'h0;
            if (s.cnt == `TIMER_PERIOD - 8'h01)
            begin
                next_s.cnt = 8'h00;
                next_s.out = ~s.out;
                next_s.trig = ~s.out;
            end
            else
            begin
                next_s.cnt = s.cnt + 8'h01;
            end
        end
        else
        begin
            next_s.pre = s.pre + 2'h1;
        end
    end

    // State register
    always_ff @(posedge clk)
    begin
        if (!rst_n)
            s <= '0;
        else if (ce)
            s <= next_s;
    end

    assign trigger = s.trig;

endmodule // sample_timer
